// File: hw/wsw_pkg.sv
// Constants, register map and state codes for the watchdog sleep/wake block
// Summary of operation
// - Watchdog counts ticks of its own oscillator, also while main clock stops.
// - Time-out while running issues an internal full device reset.
// - Time-out while asleep wakes the device and execution continues.
// - Clearing the configuration enable bit disables the watchdog for good.
// - Unscaled time-out period is nominally 18 ms.
// - Software may assign the shared prescaler to the watchdog, up to 1:128.
// - Clear-watchdog and sleep instructions clear counter and assigned prescaler.
// - A time-out clears the timeout status flag.
// - Sleep entry clears watchdog, clears powerdown, sets timeout, stops oscillator, holds pins.
// - Watchdog reset never drives the external reset pin low.
// - Wake on external reset (resets), watchdog or enabled interrupt (continues).
// - Powerdown flag set at power-up, cleared by sleep instruction.
// - Instruction after sleep is prefetched and runs first after wake.
// - Only individually enabled interrupts wake, whatever the global enable.
// - After interrupt wake, branch to vector only if global enable set.
// - Interrupt pending and enabled at sleep entry wakes at once.
// - Every wake-up clears the watchdog counter.
// - Prescale register: assign bit 3, select bits 2..0, resets to all ones.
package wsw_pkg;
   // Register indices; byte address is four times the index
   localparam int unsigned WSW_IDX_W        = 16;
   localparam logic [15:0] WSW_IDX_STATUS   = 16'h0003;
   localparam logic [15:0] WSW_IDX_PRESCALE = 16'h0081;
   localparam logic [15:0] WSW_IDX_CONFIG   = 16'h2007;
   localparam int unsigned WSW_ADDR_W       = WSW_IDX_W + 2;

   // Field positions and reset values
   localparam int unsigned WSW_PSA_BIT      = 3;
   localparam int unsigned WSW_PS_LSB       = 0;
   localparam int unsigned WSW_PS_W         = 3;
   localparam int unsigned WSW_WATCHDOG_ENABLE_FUSE_BIT     = 3;
   localparam int unsigned WSW_TO_BIT       = 4;
   localparam int unsigned WSW_PD_BIT       = 3;
   localparam logic [7:0]  WSW_PRESCALE_RST = 8'hff;
   localparam logic [7:0]  WSW_CONFIG_RST   = 8'hff;
   localparam int unsigned WSW_PRE_W        = 7;

   // Timing: nominal period and default oscillator rate
   localparam int unsigned WSW_WDT_PERIOD_US = 18000;
   localparam int unsigned WSW_OSC_KHZ_DEF   = 1000;

   typedef enum logic [1:0] {
      WSW_ST_RUN   = 2'b01,
      WSW_ST_SLEEP = 2'b10
   } wsw_state_e;
endpackage : wsw_pkg

// File: hw/wsw_sync.sv
// Two-flop synchroniser with rising-edge detector
`timescale 1ns/1ps
`default_nettype none
module wsw_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      level,
   output logic      rise
);
   logic meta_r;
   logic sync_r;
   logic hist_r;

   // First stage feeds only the second; edge taken from later stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
         hist_r <= RST_VAL;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
         hist_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise  = sync_r & ~hist_r;
endmodule : wsw_sync
`default_nettype wire

// File: hw/wsw_watchdog_sleep_wake.sv
// Top of the watchdog and sleep/wake control, with APB register access
`timescale 1ns/1ps
`default_nettype none
module wsw_watchdog_sleep_wake import wsw_pkg::*; #(
   parameter int unsigned NUM_IRQ      = 8,
   parameter int unsigned OSC_KHZ      = WSW_OSC_KHZ_DEF,
   parameter int unsigned PERIOD_TICKS = (WSW_WDT_PERIOD_US * OSC_KHZ) / 1000,
   parameter int unsigned CNT_W        = 16
) (
   input  wire logic                  SYS_CLK,
   input  wire logic                  RESET_N,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [WSW_ADDR_W-1:0] PADDR,
   input  wire logic [31:0]           PWDATA,
   output logic      [31:0]           PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   input  wire logic                  WDOG_OSC,
   output logic                       WDOG_OSC_EN,
   input  wire logic                  EXT_RESET_N_PIN,
   input  wire logic                  CLR_WDT_INSTR,
   input  wire logic                  SLEEP_INSTR,
   input  wire logic [NUM_IRQ-1:0]    INT_ENABLE,
   input  wire logic [NUM_IRQ-1:0]    INT_FLAG,
   input  wire logic                  GLOBAL_INT_EN,
   output logic                       OSC_DRIVER_OFF,
   output logic                       IO_HOLD,
   output logic                       WAKE_PULSE,
   output logic                       WAKE_TO_VECTOR,
   output logic                       DEVICE_RESET
);
   if (NUM_IRQ < 1 || NUM_IRQ > 32) begin : g_bad_irq
      $error("NUM_IRQ out of range");
   end
   if (OSC_KHZ < 1) begin : g_bad_osc
      $error("OSC_KHZ must be positive");
   end

   // Byte-address match of an aligned register word
   function automatic logic reg_hit(input logic [WSW_ADDR_W-1:0] addr,
                                    input logic [WSW_IDX_W-1:0]  idx);
      reg_hit = (addr[1:0] == 2'b00) && (addr[WSW_ADDR_W-1:2] == idx);
   endfunction : reg_hit

   // Reset release through two flops; only the second copy is used
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Pin inputs are asynchronous to SYS_CLK
   logic osc_tick;
   logic ext_rst_n_s;

   wsw_sync #(
      .RST_VAL (1'b0)
   ) u_osc_sync (
      .clk   (SYS_CLK),
      .rst_n (rst_n),
      .din   (WDOG_OSC),
      .level (),
      .rise  (osc_tick)
   );

   wsw_sync #(
      .RST_VAL (1'b1)
   ) u_pin_sync (
      .clk   (SYS_CLK),
      .rst_n (rst_n),
      .din   (EXT_RESET_N_PIN),
      .level (ext_rst_n_s),
      .rise  ()
   );

   // Register state
   logic [7:0] prescale_r;
   logic [7:0] prescale_nxt;
   logic [7:0] config_r;
   logic [7:0] config_nxt;
   logic       to_flag_r;
   logic       to_flag_nxt;
   logic       pd_flag_r;
   logic       pd_flag_nxt;
   logic [31:0] prdata_r;

   // Control state
   wsw_state_e state_r;
   wsw_state_e state_nxt;
   logic       wake_r;
   logic       wake_vec_r;
   logic       dev_rst_r;
   logic       dev_rst_nxt;
   logic       sleep_r;

   // APB decode
   logic       setup;
   logic       access;
   logic       hit_status;
   logic       hit_prescale;
   logic       hit_config;
   logic       mapped;
   logic       wr_en;
   logic [7:0] status_val;
   logic [31:0] rd_mux;

   assign setup        = PSEL & ~PENABLE;
   assign access       = PSEL & PENABLE;
   assign hit_status   = reg_hit(PADDR, WSW_IDX_STATUS);
   assign hit_prescale = reg_hit(PADDR, WSW_IDX_PRESCALE);
   assign hit_config   = reg_hit(PADDR, WSW_IDX_CONFIG);
   assign mapped       = hit_status | hit_prescale | hit_config;
   assign wr_en        = access & PWRITE & mapped;

   // Status bits read back at their own positions, rest zero
   assign status_val = (8'(to_flag_r) << WSW_TO_BIT) | (8'(pd_flag_r) << WSW_PD_BIT);
   assign rd_mux     = hit_status   ? {24'h000000, status_val} :
                       hit_prescale ? {24'h000000, prescale_r} :
                       hit_config   ? {24'h000000, config_r}   : 32'h00000000;

   // Zero-wait slave; unmapped access answers with an error
   assign PREADY  = 1'b1;
   assign PSLVERR = access & ~mapped;
   assign PRDATA  = prdata_r;

   // Register writes; enable bit can only be cleared, never set again
   assign prescale_nxt = (wr_en & hit_prescale) ? PWDATA[7:0] : prescale_r;
   always_comb begin
      config_nxt = config_r;
      if (wr_en & hit_config) begin
         config_nxt = PWDATA[7:0];
         config_nxt[WSW_WATCHDOG_ENABLE_FUSE_BIT] = PWDATA[WSW_WATCHDOG_ENABLE_FUSE_BIT] & config_r[WSW_WATCHDOG_ENABLE_FUSE_BIT];
      end
   end

   // Watchdog counter hookup
   wsw_wdog_if wif ();
   logic fuse_en;
   logic tout;
   logic pend;
   logic wdog_clear;

   assign fuse_en    = config_r[WSW_WATCHDOG_ENABLE_FUSE_BIT];
   assign tout       = wif.timeout;
   assign pend       = |(INT_ENABLE & INT_FLAG);
   assign wif.tick   = osc_tick & fuse_en;
   assign wif.enable = fuse_en;
   assign wif.prescaler_assign    = prescale_r[WSW_PSA_BIT];
   assign wif.ps     = prescale_r[WSW_PS_LSB +: WSW_PS_W];
   // Clear on instruction, sleep entry and every wake; reset also restarts it
   assign wif.clear  = wdog_clear;
   assign WDOG_OSC_EN = fuse_en;

   wsw_wdog_counter #(
      .PERIOD_TICKS (PERIOD_TICKS),
      .CNT_W        (CNT_W)
   ) u_counter (
      .clk   (SYS_CLK),
      .rst_n (rst_n),
      .wif   (wif)
   );

   // Run/sleep sequencing and flag updates
   logic wake_now;
   logic ext_rst;

   assign ext_rst = ~ext_rst_n_s;

   always_comb begin
      state_nxt   = state_r;
      to_flag_nxt = to_flag_r;
      pd_flag_nxt = pd_flag_r;
      dev_rst_nxt = 1'b0;
      wake_now    = 1'b0;
      wdog_clear  = CLR_WDT_INSTR;
      case (state_r)
         WSW_ST_RUN: begin
            if (ext_rst) begin
               dev_rst_nxt = 1'b1;
               wdog_clear  = 1'b1;
            end else if (SLEEP_INSTR) begin
               state_nxt   = WSW_ST_SLEEP;
               wdog_clear  = 1'b1;
               pd_flag_nxt = 1'b0;
               to_flag_nxt = 1'b1;
            end else if (CLR_WDT_INSTR) begin
               to_flag_nxt = 1'b1;
               pd_flag_nxt = 1'b1;
            end else if (tout) begin
               dev_rst_nxt = 1'b1;
               to_flag_nxt = 1'b0;
               wdog_clear  = 1'b1;
            end
         end
         WSW_ST_SLEEP: begin
            if (ext_rst) begin
               state_nxt   = WSW_ST_RUN;
               dev_rst_nxt = 1'b1;
               wdog_clear  = 1'b1;
            end else if (tout | pend) begin
               state_nxt   = WSW_ST_RUN;
               wake_now    = 1'b1;
               wdog_clear  = 1'b1;
               if (tout) begin
                  to_flag_nxt = 1'b0;
               end
            end
         end
         default: begin
            state_nxt  = WSW_ST_RUN;
            wdog_clear = 1'b1;
         end
      endcase
   end

   // Register and control flops
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         prescale_r <= WSW_PRESCALE_RST;
         config_r   <= WSW_CONFIG_RST;
         to_flag_r  <= 1'b1;
         pd_flag_r  <= 1'b1;
         prdata_r   <= 32'h00000000;
         state_r    <= WSW_ST_RUN;
         wake_r     <= 1'b0;
         wake_vec_r <= 1'b0;
         dev_rst_r  <= 1'b0;
         sleep_r    <= 1'b0;
      end else begin
         prescale_r <= prescale_nxt;
         config_r   <= config_nxt;
         to_flag_r  <= to_flag_nxt;
         pd_flag_r  <= pd_flag_nxt;
         prdata_r   <= setup ? rd_mux : prdata_r;
         state_r    <= state_nxt;
         wake_r     <= wake_now;
         wake_vec_r <= wake_now ? GLOBAL_INT_EN : wake_vec_r;
         dev_rst_r  <= dev_rst_nxt;
         sleep_r    <= (state_nxt == WSW_ST_SLEEP);
      end
   end

   // Core runs its prefetched next instruction on wake; vector flag follows
   assign WAKE_PULSE     = wake_r;
   assign WAKE_TO_VECTOR = wake_vec_r;
   // Internal reset only; the external pin is an input and never driven
   assign DEVICE_RESET   = dev_rst_r;
   // Oscillator driver off and pins frozen while asleep
   assign OSC_DRIVER_OFF = sleep_r;
   assign IO_HOLD        = sleep_r;

   tout_reset_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (state_r == WSW_ST_RUN) && tout && !ext_rst && !SLEEP_INSTR && !CLR_WDT_INSTR
      |=> DEVICE_RESET && !WAKE_PULSE && !to_flag_r)
      else $error("run time-out gave no reset");

   sleep_wake_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (state_r == WSW_ST_SLEEP) && tout && !ext_rst
      |=> WAKE_PULSE && !DEVICE_RESET && (state_r == WSW_ST_RUN) && !to_flag_r)
      else $error("sleep time-out did not wake");

   sleep_entry_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (state_r == WSW_ST_RUN) && SLEEP_INSTR && !ext_rst
      |=> !pd_flag_r && to_flag_r && OSC_DRIVER_OFF && IO_HOLD)
      else $error("sleep entry effects missing");

   fuse_sticky_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      !fuse_en |=> !fuse_en)
      else $error("watchdog enable came back");

   int_wake_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (state_r == WSW_ST_SLEEP) && pend && !ext_rst |=> WAKE_PULSE)
      else $error("enabled interrupt did not wake");

   no_wake_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (state_r == WSW_ST_SLEEP) && !pend && !tout |=> !WAKE_PULSE)
      else $error("wake without cause");

   vec_sel_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      wake_now |=> WAKE_TO_VECTOR == $past(GLOBAL_INT_EN))
      else $error("vector choice wrong");

   early_wake_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (state_r == WSW_ST_RUN) && SLEEP_INSTR && pend && !ext_rst
      |=> ##1 WAKE_PULSE)
      else $error("pending interrupt did not wake at once");

   wake_clear_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      wake_now |-> wdog_clear ##1 !tout)
      else $error("wake did not clear watchdog");

   ext_reset_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      ext_rst |=> DEVICE_RESET && (state_r == WSW_ST_RUN))
      else $error("external reset ignored");

   pd_sleep_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      $fell(pd_flag_r) |-> $past(SLEEP_INSTR) && $past(state_r == WSW_ST_RUN))
      else $error("powerdown cleared without sleep");
endmodule : wsw_watchdog_sleep_wake
`default_nettype wire

// File: hw/wsw_wdog_counter.sv
// Watchdog prescaler and period counter, stepped by oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module wsw_wdog_counter import wsw_pkg::*; #(
   parameter int unsigned PERIOD_TICKS = 18000,
   parameter int unsigned CNT_W        = 16
) (
   input  wire logic clk,
   input  wire logic rst_n,
   wsw_wdog_if.cnt   wif
);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_TICKS - 1);

   if (PERIOD_TICKS < 2 || PERIOD_TICKS > (2 ** CNT_W)) begin : g_bad_period
      $error("PERIOD_TICKS does not fit CNT_W");
   end

   // Power-of-two terminal count of the prescaler
   function automatic logic [WSW_PRE_W-1:0] pre_mask(input logic [2:0] sel);
      pre_mask = WSW_PRE_W'((32'h1 << sel) - 32'h1);
   endfunction : pre_mask

   logic [WSW_PRE_W-1:0] pre_r;
   logic [WSW_PRE_W-1:0] pre_nxt;
   logic [CNT_W-1:0]     cnt_r;
   logic [CNT_W-1:0]     cnt_nxt;
   logic                 timeout_r;
   logic                 hold;
   logic                 pre_hit;
   logic                 scaled;
   logic                 base_hit;

   // Disabled or cleared counters sit at zero
   assign hold     = ~wif.enable | wif.clear;
   assign pre_hit  = ~wif.prescaler_assign | (pre_r == pre_mask(wif.ps));
   assign scaled   = wif.tick & pre_hit;
   assign base_hit = scaled & (cnt_r == LAST);
   assign pre_nxt  = (hold | ~wif.prescaler_assign | (wif.tick & pre_hit)) ? '0 :
                     (wif.tick ? pre_r + 1'b1 : pre_r);
   assign cnt_nxt  = (hold | base_hit) ? '0 : (scaled ? cnt_r + 1'b1 : cnt_r);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r     <= '0;
         cnt_r     <= '0;
         timeout_r <= 1'b0;
      end else begin
         pre_r     <= pre_nxt;
         cnt_r     <= cnt_nxt;
         timeout_r <= ~hold & base_hit;
      end
   end

   assign wif.timeout = timeout_r;

   clear_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      wif.clear |=> (cnt_r == '0) && (pre_r == '0))
      else $error("watchdog not cleared");
   fuse_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      !wif.enable |=> !timeout_r && (cnt_r == '0))
      else $error("disabled watchdog active");
   period_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
      timeout_r |-> $past(cnt_r) == LAST)
      else $error("time-out at wrong count");
endmodule : wsw_wdog_counter
`default_nettype wire

// File: hw/wsw_wdog_if.sv
// Interface between the sleep/wake control and the watchdog counter
`timescale 1ns/1ps
`default_nettype none
interface wsw_wdog_if;
   logic       tick;
   logic       clear;
   logic       enable;
   logic       prescaler_assign;
   logic [2:0] ps;
   logic       timeout;
   modport ctl (output tick, output clear, output enable, output prescaler_assign, output ps,
                input timeout);
   modport cnt (input tick, input clear, input enable, input prescaler_assign, input ps,
                output timeout);
endinterface : wsw_wdog_if
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the watchdog sleep/wake block
`timescale 1ns/1ps
`default_nettype none
module testbench import wsw_pkg::*;;
   localparam int          PT    = 4;
   localparam int          LIMIT = 40000;
   localparam logic [17:0] A_ST  = {WSW_IDX_STATUS, 2'b00};
   localparam logic [17:0] A_PS  = {WSW_IDX_PRESCALE, 2'b00};
   localparam logic [17:0] A_CF  = {WSW_IDX_CONFIG, 2'b00};
   logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
   logic        osc, osc_en, ext_n, clr, slp, global_interrupt_enable, osc_off, io_hold, wake, to_vec, dev_rst;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  ien, ifl;
   int          err_count, n_checks, cyc, rst_cnt, wake_cnt, n, m, w;

   wsw_watchdog_sleep_wake #(.PERIOD_TICKS(PT)) wsw_watchdog_sleep_wake_inst (
      .SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .WDOG_OSC(osc), .WDOG_OSC_EN(osc_en),
      .EXT_RESET_N_PIN(ext_n), .CLR_WDT_INSTR(clr), .SLEEP_INSTR(slp),
      .INT_ENABLE(ien), .INT_FLAG(ifl), .GLOBAL_INT_EN(global_interrupt_enable), .OSC_DRIVER_OFF(osc_off),
      .IO_HOLD(io_hold), .WAKE_PULSE(wake), .WAKE_TO_VECTOR(to_vec), .DEVICE_RESET(dev_rst));

   wsw_core #(.NIRQ(8)) wsw_core_inst (
      .clk(sys_clk), .osc_en(osc_en), .wake(wake), .wdog_osc(osc), .clr_wdt(clr),
      .sleep(slp), .int_en(ien), .int_flag(ifl), .global_interrupt_enable(global_interrupt_enable));

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Event counters and hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (dev_rst === 1'b1) rst_cnt <= rst_cnt + 1;
      if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
      if (cyc == LIMIT) begin
         err_count = err_count + 1;
         $display("unexpected timeout: expected end before %0d cycles, seen %0d", LIMIT, cyc);
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic chk_rng(input string nm, input int lo, input int hi, input int v);
      n_checks++;
      if (v < lo || v > hi) begin
         err_count++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, v);
      end
   endtask : chk_rng

   // Zero-wait slaves still get the full wait on pready
   task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Edges until wake or reset pulse; -1 if it never came
   task automatic wait_for(input bit wk, input int lim, output int cnt);
      cnt = -1;
      for (int i = 1; i <= lim && cnt < 0; i++) begin
         @(posedge sys_clk);
         #1;
         if ((wk ? wake : dev_rst) === 1'b1) cnt = i;
      end
   endtask : wait_for

   task automatic test_done;
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   initial begin
      {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
      ext_n = 1'b1;
      {err_count, n_checks, cyc, rst_cnt, wake_cnt} = '0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      // Reset values, read-only status, unmapped and unaligned places
      apb(0, A_PS, 0);
      chk("prescale reset", 32'hff, rd);
      apb(0, A_CF, 0);
      chk("config reset", 32'hff, rd);
      apb(1, A_ST, 0);
      apb(0, A_ST, 0);
      chk("status reset", 32'h18, rd);
      apb(0, 18'h00100, 0);
      chk("unmapped err", 1, er);
      chk("unmapped data", 0, rd);
      apb(1, A_PS + 18'd1, 0);
      chk("unaligned err", 1, er);
      $display("test registers done");
      // Unscaled time-out resets the device and clears the timeout flag
      apb(1, A_PS, 32'h00);
      apb(0, A_PS, 0);
      chk("prescale rw", 32'h00, rd);
      wsw_core_inst.instr(0);
      wait_for(0, PT * 8 + 20, n);
      chk_rng("timeout cycles", (PT - 1) * 8, PT * 8 + 12, n);
      apb(0, A_ST, 0);
      chk("status after timeout", 32'h08, rd);
      wsw_core_inst.instr(0);
      apb(0, A_ST, 0);
      chk("status after clear", 32'h18, rd);
      // Regular clearing keeps the device alive
      m = rst_cnt;
      repeat (12) begin
         wsw_core_inst.instr(0);
         repeat (14) @(posedge sys_clk);
      end
      chk("resets while cleared", m, rst_cnt);
      $display("test timeout done");
      // Every prescale ratio; longest run dominates the test time
      for (int s = 0; s < 8; s++) begin
         apb(1, A_PS, 32'h08 | s);
         wsw_core_inst.instr(0);
         wait_for(0, (PT << s) * 8 + 20, n);
         chk_rng("scaled timeout", ((PT << s) - 1) * 8, (PT << s) * 8 + 12, n);
      end
      $display("test prescale done");
      // Sleep clears the watchdog, which then wakes instead of resetting
      apb(1, A_PS, 32'h08);
      wsw_core_inst.instr(0);
      repeat (20) @(posedge sys_clk);
      m = rst_cnt;
      wsw_core_inst.instr(1);
      #1;
      chk("osc driver off", 1, osc_off);
      chk("io hold", 1, io_hold);
      apb(0, A_ST, 0);
      chk("status asleep", 32'h10, rd);
      wait_for(1, PT * 8 + 20, n);
      chk_rng("watchdog wake", (PT - 1) * 8 - 4, PT * 8 + 12, n);
      chk("no reset in sleep", m, rst_cnt);
      chk("osc driver back", 0, osc_off);
      apb(0, A_ST, 0);
      chk("status watchdog wake", 32'h00, rd);
      $display("test sleep done");
      // Only enabled sources wake; global enable picks the vector
      apb(1, A_PS, 32'h0f);
      for (int g = 0; g < 2; g++) begin
         wsw_core_inst.irq(8'h00, 8'h20, g[0]);
         wsw_core_inst.instr(1);
         wait_for(1, 6, n);
         chk("masked wake", -1, n);
         wsw_core_inst.irq(8'h20, 8'h20, g[0]);
         wait_for(1, 4, n);
         chk("irq wake cycles", 1, n);
         chk("to vector", g, to_vec);
         wsw_core_inst.irq(8'h00, 8'h00, 1'b0);
      end
      // Pending enabled source at sleep entry wakes at once
      apb(1, A_PS, 32'h00);
      wsw_core_inst.instr(0);
      wsw_core_inst.irq(8'h01, 8'h01, 1'b0);
      wsw_core_inst.instr(1);
      wait_for(1, 4, n);
      chk("pending wake cycles", 1, n);
      wsw_core_inst.irq(8'h00, 8'h00, 1'b0);
      // Wake clears the counter: a full period follows
      wsw_core_inst.instr(1);
      repeat (18) @(posedge sys_clk);
      wsw_core_inst.irq(8'h80, 8'h80, 1'b0);
      wait_for(1, 4, n);
      wsw_core_inst.irq(8'h00, 8'h00, 1'b0);
      wait_for(0, PT * 8 + 20, n);
      chk_rng("timeout after wake", (PT - 1) * 8 - 2, PT * 8 + 12, n);
      $display("test interrupt wake done");
      // Pin reset in sleep resets and does not resume
      apb(1, A_PS, 32'h0f);
      wsw_core_inst.instr(1);
      w = wake_cnt;
      @(posedge sys_clk);
      ext_n <= 1'b0;
      wait_for(0, 6, n);
      chk_rng("pin reset latency", 1, 5, n);
      @(posedge sys_clk);
      ext_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("no wake on pin", w, wake_cnt);
      $display("test pin reset done");
      // Disable bit sticks and silences the watchdog, also asleep
      apb(1, A_CF, 32'hf7);
      #1;
      chk("osc enable off", 0, osc_en);
      apb(1, A_CF, 32'hff);
      apb(0, A_CF, 0);
      chk("config sticky", 32'hf7, rd);
      apb(1, A_PS, 32'h00);
      m = rst_cnt;
      w = wake_cnt;
      wsw_core_inst.instr(1);
      repeat (200) @(posedge sys_clk);
      chk("resets disabled", m, rst_cnt);
      chk("wakes disabled", w, wake_cnt);
      chk("core resumes", wake_cnt, wsw_core_inst.resumed);
      $display("test disable done");
      test_done();
   end
endmodule : testbench
`default_nettype wire

// File: test/wsw_core.sv
// Behavioural processor core: instruction pulses, interrupt lines, watchdog oscillator
`timescale 1ns/1ps
`default_nettype none
module wsw_core #(
   parameter int NIRQ = 8
) (
   input  wire logic        clk,
   input  wire logic        osc_en,
   input  wire logic        wake,
   output logic             wdog_osc,
   output logic             clr_wdt,
   output logic             sleep,
   output logic [NIRQ-1:0]  int_en,
   output logic [NIRQ-1:0]  int_flag,
   output logic             global_interrupt_enable
);
   logic [1:0] div_r;
   int         resumed;

   // Quiet start, oscillator low
   initial begin
      wdog_osc = 1'b0;
      clr_wdt = 1'b0;
      sleep = 1'b0;
      global_interrupt_enable = 1'b0;
      div_r = 2'd0;
      int_en = '0;
      int_flag = '0;
      resumed = 0;
   end

   // Own oscillator, eight clocks a period; stands still when switched off
   always @(posedge clk) begin
      if (osc_en === 1'b1) begin
         div_r <= div_r + 2'd1;
         if (div_r == 2'd3) wdog_osc <= ~wdog_osc;
      end
   end

   // Resume at the prefetched instruction; software parks a no-op there
   always @(posedge clk) begin
      if (wake === 1'b1) resumed <= resumed + 1;
   end

   // One-cycle clear-watchdog or sleep instruction
   task automatic instr(input bit slp);
      @(posedge clk);
      if (slp) sleep <= 1'b1;
      else clr_wdt <= 1'b1;
      @(posedge clk);
      sleep <= 1'b0;
      clr_wdt <= 1'b0;
   endtask : instr

   // Interrupt enables, flags and global enable
   task automatic irq(input logic [NIRQ-1:0] en, input logic [NIRQ-1:0] fl, input logic g);
      @(posedge clk);
      int_en <= en;
      int_flag <= fl;
      global_interrupt_enable <= g;
   endtask : irq
endmodule : wsw_core
`default_nettype wire
